/* hdl/nva_consts.vh */
// Constants for the nonvolatile access unit: register offsets, fields, timing.
// Assumes a plain register port with one-cycle strobes and read data one cycle later.
// Function
// - Arrays reached only indirectly through six dedicated registers; the code uses seven, adding a status register.
// - Data access uses low data register byte and low address register.
// - Data memory holds 128 or 256 bytes, addresses 00h to 0FFh.
// - Small variant: data addresses 80h to FFh unimplemented, read 00h.
// - Writes to unimplemented data locations keep the pump off.
// - Program access joins data pair to 14 bits, address pair to 13 bits.
// - Program memory holds 1K or 2K words, 03FFh or 07FFh top.
// - Program addresses beyond range wrap by dropping upper bits.
// - Data memory read and written one byte per operation.
// - Program flash single-word reads, writes only in four-word blocks.
// - Data byte write erases then programs automatically.
// - Write and erase duration timed by an internal timer.
// - Code protection still allows data memory read and write.
// - Code protection gates program block writes by protect bits, reads allowed.
// - Code protection denies external programmer access, internal unaffected.
// - Memory space select clear at reset; set targets program memory.
// - Read and write triggers set-only by software, hardware clears them.
// - Write or erase starts only while write enable gate is set.
// - Write done flag set on completion, stays until software clears.
`ifndef NVA_CONSTS_VH
`define NVA_CONSTS_VH
// --------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------
`define NVA_OFS_DATA_LOW   3'h0
`define NVA_OFS_DATA_HIGH  3'h1
`define NVA_OFS_ADDR_LOW   3'h2
`define NVA_OFS_ADDR_HIGH  3'h3
`define NVA_OFS_CONTROL    3'h4
`define NVA_OFS_UNLOCK     3'h5
`define NVA_OFS_STATUS     3'h6
// --------------------------------------------------------------
// Control fields
// --------------------------------------------------------------
`define NVA_CTL_RD         0
`define NVA_CTL_WR         1
`define NVA_CTL_WRITE_ENABLE_GATE       2
`define NVA_CTL_WRERR      3
`define NVA_CTL_FREE       4
`define NVA_CTL_SPACE      7
// Status fields
`define NVA_STA_DONE       0
// Unlock sequence values
`define NVA_UNLOCK_1       8'h55
`define NVA_UNLOCK_2       8'haa
// --------------------------------------------------------------
// Timing
// --------------------------------------------------------------
`define NVA_CLK_MHZ        40
`define NVA_WRITE_US       2000
`define NVA_WRITE_CYC      (`NVA_WRITE_US * `NVA_CLK_MHZ)
`define NVA_READ_CYC       2
`endif

/* hdl/nva_timer.v */
// Operation timer: counts a loaded number of cycles, pulses done at the end.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module nva_timer #(
    parameter W = 20
) (
    // Clock and reset
    input  wire         CLOCK,
    input  wire         RST_N,
    // Control
    input  wire         START,
    input  wire [W-1:0] LOAD,
    output wire         BUSY,
    output reg          DONE
);
    reg [W-1:0] cnt_reg;
    reg         run_reg;
    assign BUSY = run_reg;
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_reg <= {W{1'b0}};
            run_reg <= 1'b0;
            DONE    <= 1'b0;
        end else begin
            DONE <= 1'b0;
            if (START && !run_reg) begin
                cnt_reg <= LOAD;
                run_reg <= 1'b1;
            end else if (run_reg) begin
                if (cnt_reg <= {{(W-1){1'b0}}, 1'b1}) begin
                    run_reg <= 1'b0;
                    DONE    <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // nva_timer

/* hdl/nva_access.v */
// Nonvolatile access unit: data EEPROM and program flash behind seven registers.
// Assumes synchronous register strobes, never both at once, and one system clock.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "nva_consts.vh"
module nva_access #(
    parameter BIG_VARIANT = 1,
    parameter WRITE_CYC   = `NVA_WRITE_CYC,
    parameter PROT_BLOCKS = 4
) (
    // Clock and reset
    input  wire        CLOCK,
    input  wire        RST_N,
    // Register port
    input  wire [2:0]  ADDR,
    input  wire [7:0]  WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [7:0]  RDATA,
    // Protection settings
    input  wire        CODE_PROTECT,
    input  wire [PROT_BLOCKS-1:0] WRITE_PROTECT,
    input  wire        EXT_PROG_REQ,
    output wire        EXT_PROG_GRANT,
    // Status
    output wire        PUMP_ON,
    output wire        WRITE_DONE_FLAG,
    output wire        BUSY
);
    localparam DW = 256;
    localparam PW = 2048;
    localparam ST_IDLE = 2'h0;
    localparam ST_READ = 2'h1;
    localparam ST_PROG = 2'h2;

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    reg [7:0]  nvm_data_low_reg;
    reg [5:0]  nvm_data_high_reg;
    reg [7:0]  nvm_addr_low_reg;
    reg [4:0]  nvm_addr_high_reg;
    reg        memory_space_select_reg;
    reg        write_enable_gate_reg;
    reg        rd_trig_reg;
    reg        wr_trig_reg;
    reg        free_reg;
    reg        wrerr_reg;
    reg        write_done_flag_reg;
    reg [1:0]  unlock_reg;
    reg [1:0]  state_reg;
    reg [1:0]  rcnt_reg;
    reg        pump_reg;
    reg        prog_space_reg;
    reg [7:0]  dmem [0:DW-1];
    reg [13:0] pmem [0:PW-1];
    reg [13:0] wbuf [0:3];
    reg [10:0] tgt_reg;
    reg [7:0]  tgt_byte_reg;
    reg [1:0]  wcount_reg;
    integer    i;

    wire       timer_busy;
    wire       timer_done;
    wire [7:0] data_addr;
    wire [10:0] prog_addr;
    wire [12:0] full_addr;
    wire       data_impl;
    wire       prog_blocked;
    wire       wr_hit;
    wire       unlocked;
    wire       start_wr;
    wire       start_rd;
    wire       ctl_write;

    // --------------------------------------------------------------
    // Address shaping
    // --------------------------------------------------------------
    assign full_addr = {nvm_addr_high_reg, nvm_addr_low_reg};
    assign data_addr = nvm_addr_low_reg;
    // Unused upper bits dropped gives wraparound
    assign prog_addr = BIG_VARIANT ? full_addr[10:0] : {1'b0, full_addr[9:0]};
    assign data_impl = BIG_VARIANT ? 1'b1 : ~data_addr[7];
    // Each protect bit guards one equal slice of the 2K-word space; the small variant reaches only the lower half
    assign prog_blocked = CODE_PROTECT &
        WRITE_PROTECT[prog_addr[10:11-$clog2(PROT_BLOCKS)]];
    assign EXT_PROG_GRANT = EXT_PROG_REQ & ~CODE_PROTECT;

    assign ctl_write = WR && (ADDR == `NVA_OFS_CONTROL);
    assign wr_hit    = ctl_write && WDATA[`NVA_CTL_WR];
    assign unlocked  = (unlock_reg == 2'h2);
    assign start_wr  = wr_hit && !wr_trig_reg && write_enable_gate_reg && unlocked
                       && (state_reg == ST_IDLE);
    assign start_rd  = ctl_write && WDATA[`NVA_CTL_RD] && !wr_hit && (state_reg == ST_IDLE);

    assign PUMP_ON = pump_reg;
    assign WRITE_DONE_FLAG = write_done_flag_reg;
    assign BUSY = (state_reg != ST_IDLE);

    // Write time comes from the internal timer, not software polling
    nva_timer #(
        .W      (32)
    ) u_timer (
        .CLOCK  (CLOCK),
        .RST_N  (RST_N),
        .START  (start_wr),
        .LOAD   (WRITE_CYC),
        .BUSY   (timer_busy),
        .DONE   (timer_done)
    );

    // --------------------------------------------------------------
    // Register writes and operation sequencing
    // --------------------------------------------------------------
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            nvm_data_low_reg        <= 8'h00;
            nvm_data_high_reg       <= 6'h00;
            nvm_addr_low_reg        <= 8'h00;
            nvm_addr_high_reg       <= 5'h00;
            memory_space_select_reg <= 1'b0;
            write_enable_gate_reg   <= 1'b0;
            rd_trig_reg             <= 1'b0;
            wr_trig_reg             <= 1'b0;
            free_reg                <= 1'b0;
            wrerr_reg               <= 1'b0;
            write_done_flag_reg     <= 1'b0;
            unlock_reg              <= 2'h0;
            state_reg               <= ST_IDLE;
            rcnt_reg                <= 2'h0;
            pump_reg                <= 1'b0;
            prog_space_reg          <= 1'b0;
            tgt_reg                 <= 11'h000;
            tgt_byte_reg            <= 8'h00;
            wcount_reg              <= 2'h0;
        end else begin
            if (WR) begin
                case (ADDR)
                    `NVA_OFS_DATA_LOW:  nvm_data_low_reg  <= WDATA;
                    `NVA_OFS_DATA_HIGH: nvm_data_high_reg <= WDATA[5:0];
                    `NVA_OFS_ADDR_LOW:  nvm_addr_low_reg  <= WDATA;
                    `NVA_OFS_ADDR_HIGH: nvm_addr_high_reg <= WDATA[4:0];
                    `NVA_OFS_CONTROL: begin
                        memory_space_select_reg <= WDATA[`NVA_CTL_SPACE];
                        write_enable_gate_reg   <= WDATA[`NVA_CTL_WRITE_ENABLE_GATE];
                        free_reg                <= WDATA[`NVA_CTL_FREE];
                        if (!WDATA[`NVA_CTL_WRERR])
                            wrerr_reg <= 1'b0;
                    end
                    `NVA_OFS_STATUS: begin
                        if (!WDATA[`NVA_STA_DONE])
                            write_done_flag_reg <= 1'b0;
                    end
                    default: ;
                endcase
            end
            // Two-step unlock; any other write to it restarts the sequence
            if (WR && ADDR == `NVA_OFS_UNLOCK) begin
                if (WDATA == `NVA_UNLOCK_1)
                    unlock_reg <= 2'h1;
                else if (WDATA == `NVA_UNLOCK_2 && unlock_reg == 2'h1)
                    unlock_reg <= 2'h2;
                else
                    unlock_reg <= 2'h0;
            end else if (wr_hit) begin
                unlock_reg <= 2'h0;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (start_wr) begin
                        wr_trig_reg    <= 1'b1;
                        prog_space_reg <= memory_space_select_reg;
                        tgt_reg        <= prog_addr;
                        tgt_byte_reg   <= data_addr;
                        state_reg      <= ST_PROG;
                        if (!memory_space_select_reg)
                            pump_reg <= data_impl;
                        else
                            pump_reg <= ~prog_blocked &
                                        (free_reg | wcount_reg == 2'h3);
                    end else if (start_rd) begin
                        rd_trig_reg <= 1'b1;
                        rcnt_reg    <= 2'h0;
                        state_reg   <= ST_READ;
                    end
                end
                ST_READ: begin
                    rcnt_reg <= rcnt_reg + 2'h1;
                    if (rcnt_reg == `NVA_READ_CYC - 1) begin
                        if (memory_space_select_reg) begin
                            nvm_data_low_reg  <= pmem[prog_addr][7:0];
                            nvm_data_high_reg <= pmem[prog_addr][13:8];
                        end else begin
                            nvm_data_low_reg <= data_impl ? dmem[data_addr] : 8'h00;
                        end
                        rd_trig_reg <= 1'b0;
                        state_reg   <= ST_IDLE;
                    end
                end
                ST_PROG: begin
                    if (timer_done) begin
                        wr_trig_reg         <= 1'b0;
                        pump_reg            <= 1'b0;
                        write_done_flag_reg <= 1'b1;
                        state_reg           <= ST_IDLE;
                        if (prog_space_reg && !free_reg)
                            wcount_reg <= wcount_reg + 2'h1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Array contents; no reset, like real cells
    // --------------------------------------------------------------
    always @(posedge CLOCK) begin
        if (state_reg == ST_IDLE && start_wr && memory_space_select_reg && !free_reg)
            wbuf[prog_addr[1:0]] <= {nvm_data_high_reg, nvm_data_low_reg};
        if (state_reg == ST_PROG && timer_done && pump_reg) begin
            if (!prog_space_reg) begin
                dmem[tgt_byte_reg] <= nvm_data_low_reg;
            end else if (free_reg) begin
                // Erase clears a 32-word block to all ones
                for (i = 0; i < 32; i = i + 1)
                    pmem[{tgt_reg[10:5], i[4:0]}] <= 14'h3fff;
            end else begin
                for (i = 0; i < 4; i = i + 1)
                    pmem[{tgt_reg[10:2], i[1:0]}] <= wbuf[i];
            end
        end
    end

    // --------------------------------------------------------------
    // Read path, one cycle after the strobe
    // --------------------------------------------------------------
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                `NVA_OFS_DATA_LOW:  RDATA <= nvm_data_low_reg;
                `NVA_OFS_DATA_HIGH: RDATA <= {2'h0, nvm_data_high_reg};
                `NVA_OFS_ADDR_LOW:  RDATA <= nvm_addr_low_reg;
                `NVA_OFS_ADDR_HIGH: RDATA <= {3'h0, nvm_addr_high_reg};
                `NVA_OFS_CONTROL:   RDATA <= {memory_space_select_reg, 2'h0, free_reg,
                                              wrerr_reg, write_enable_gate_reg,
                                              wr_trig_reg, rd_trig_reg};
                `NVA_OFS_STATUS:    RDATA <= {7'h00, write_done_flag_reg};
                default:            RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end
endmodule // nva_access

/* testbench/nva_access_asserts.sv */
// Checker for the nonvolatile access unit, watching only its top ports.
// Assumes one clock domain and a shortened write time handed on by the bind.
`timescale 1ns/1ps
module nva_access_asserts #(
    parameter WRITE_CYC = 8
) (
    // Clock and reset
    input wire       CLOCK,
    input wire       RST_N,
    // Register port
    input wire [2:0] ADDR,
    input wire [7:0] WDATA,
    input wire       WR,
    input wire       RD,
    input wire [7:0] RDATA,
    // Protection and status
    input wire       CODE_PROTECT,
    input wire       EXT_PROG_REQ,
    input wire       EXT_PROG_GRANT,
    input wire       PUMP_ON,
    input wire       WRITE_DONE_FLAG,
    input wire       BUSY
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // ----------------------------------------
    // Pump length counter
    // ----------------------------------------
    // A counter, since the real write time is far beyond any repetition count
    reg [31:0] pump_cnt_reg;
    always @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pump_cnt_reg <= 32'h0;
        end else if (PUMP_ON) begin
            pump_cnt_reg <= pump_cnt_reg + 32'h1;
        end else begin
            pump_cnt_reg <= 32'h0;
        end
    end
    property p_grant; EXT_PROG_GRANT == (EXT_PROG_REQ && !CODE_PROTECT); endproperty
    a_grant: assert property (p_grant) else $error("programmer grant wrong");
    property p_rdata_idle; !RD |=> RDATA == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
    property p_unlock_zero; RD && (ADDR == 3'h5 || ADDR == 3'h7) |=> RDATA == 8'h00; endproperty
    a_unlock_zero: assert property (p_unlock_zero) else $error("unlock reads nonzero");
    property p_pump_in_busy; PUMP_ON |-> BUSY; endproperty
    a_pump_in_busy: assert property (p_pump_in_busy) else $error("pump on while idle");
    property p_pump_bounded; pump_cnt_reg <= WRITE_CYC + 1; endproperty
    a_pump_bounded: assert property (p_pump_bounded) else $error("pump on too long");
    property p_flag_after_pump; $fell(PUMP_ON) |-> ##[0:2] WRITE_DONE_FLAG; endproperty
    a_flag_after_pump: assert property (p_flag_after_pump) else $error("no done flag");
    property p_flag_sticky; WRITE_DONE_FLAG && !(WR && ADDR == 3'h6) |=> WRITE_DONE_FLAG; endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("done flag dropped");
    property p_flag_cause; $rose(WRITE_DONE_FLAG) |-> $past(BUSY); endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag without operation");
    property p_busy_cause; $rose(BUSY) |-> $past(WR && ADDR == 3'h4 && WDATA[1:0] != 2'b00); endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without trigger");
    property p_busy_ends; BUSY |-> ##[1:40] !BUSY; endproperty
    a_busy_ends: assert property (p_busy_ends) else $error("busy never clears");
endmodule // nva_access_asserts

/* testbench/tb_nva_access.sv */
// Self-checking bench for the nonvolatile access unit, small variant.
// Assumes the design files and their constants header on the include path.
`timescale 1ns/1ps
module tb_nva_access;
    reg         clock, rst_n, wr_stb, rd_stb, code_protect, ext_prog_req;
    reg  [2:0]  addr;
    reg  [7:0]  wdata, rv, a8;
    reg  [3:0]  write_protect;
    reg  [31:0] seed;
    reg  [15:0] d16, pump_cnt, pump_mark;
    reg  [13:0] word [0:3];
    wire [7:0]  rdata;
    wire        ext_prog_grant, pump_on, write_done_flag, busy;
    integer     fails, check_count, i;
    nva_access #(.BIG_VARIANT(0), .WRITE_CYC(8), .PROT_BLOCKS(4)) u_nva_access (
        .CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_stb), .RD(rd_stb),
        .RDATA(rdata), .CODE_PROTECT(code_protect), .WRITE_PROTECT(write_protect),
        .EXT_PROG_REQ(ext_prog_req), .EXT_PROG_GRANT(ext_prog_grant), .PUMP_ON(pump_on),
        .WRITE_DONE_FLAG(write_done_flag), .BUSY(busy));
    always #12.5 clock = ~clock;
    // Counts the edges at which the pump stands, so the write time can be checked
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pump_cnt <= 16'h0000;
        end else if (pump_on === 1'b1) begin
            pump_cnt <= pump_cnt + 16'h0001;
        end
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // The small variant answers zero above its 128 bytes
    function [7:0] exp_byte(input [7:0] a, input [7:0] d);
        exp_byte = a[7] ? 8'h00 : d;
    endfunction
    task chk(input [15:0] seen, input [15:0] exp, input [8*10:1] nm);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("unexpected %0s: expected %h, seen %h", nm, exp, seen);
            end
        end
    endtask
    task reg_wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge clock);
            wr_stb <= 1'b1; addr <= a; wdata <= d;
            @(posedge clock);
            wr_stb <= 1'b0;
        end
    endtask
    task reg_rd(input [2:0] a, output [7:0] d);
        begin
            @(posedge clock);
            rd_stb <= 1'b1; addr <= a;
            @(posedge clock);
            rd_stb <= 1'b0;
            #1 d = rdata;
        end
    endtask
    task wait_idle;
        integer n;
        begin
            n = 0;
            // Busy settles only after the edge that took the trigger
            #1;
            while (busy !== 1'b0 && n < 60) begin
                @(posedge clock);
                #1;
                n = n + 1;
            end
            chk(n < 60, 1, "idle wait");
        end
    endtask
    task set_addr(input [15:0] a);
        begin
            reg_wr(3'h2, a[7:0]);
            reg_wr(3'h3, a[15:8]);
        end
    endtask
    // Gate first, then unlock, then trigger: the gate must already stand
    task nvm_write(input [7:0] ctl, input [15:0] a, input [15:0] d);
        begin
            set_addr(a);
            reg_wr(3'h0, d[7:0]);
            reg_wr(3'h1, d[15:8]);
            reg_wr(3'h4, ctl);
            reg_wr(3'h5, 8'h55);
            reg_wr(3'h5, 8'haa);
            reg_wr(3'h4, ctl | 8'h02);
            wait_idle;
        end
    endtask
    task nvm_read(input [7:0] space, input [15:0] a, output [15:0] d);
        begin
            set_addr(a);
            reg_wr(3'h4, space | 8'h01);
            repeat (3) @(posedge clock);
            reg_rd(3'h0, d[7:0]);
            reg_rd(3'h1, d[15:8]);
        end
    endtask
    task end_of_test;
        begin
            if (fails == 0 && check_count > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    initial begin
        #(25 * 20000);
        fails = fails + 1;
        end_of_test;
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clock = 0; rst_n = 0; addr = 0; wdata = 0; wr_stb = 0; rd_stb = 0; code_protect = 0;
        write_protect = 0; ext_prog_req = 1; fails = 0; check_count = 0;
        seed = 32'd27;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        reg_rd(3'h4, rv); chk(rv, 0, "control");
        reg_rd(3'h6, rv); chk(rv, 0, "status");
        reg_rd(3'h5, rv); chk(rv, 0, "unlock");
        chk(ext_prog_grant, 1, "grant");
        // Top implemented byte, an unimplemented one, then random bytes
        for (i = 0; i < 6; i = i + 1) begin
            seed = xs(seed);
            a8 = (i == 0) ? 8'h7f : (i == 1) ? 8'h90 : {1'b0, seed[14:8]};
            pump_mark = pump_cnt;
            nvm_write(8'h04, {8'h00, a8}, {8'h00, seed[7:0]});
            chk(pump_cnt - pump_mark, a8[7] ? 16'h0000 : 16'h0009, "pump time");
            reg_rd(3'h6, rv); chk(rv[0], 1, "done flag");
            reg_rd(3'h4, rv); chk(rv[1:0], 0, "triggers");
            reg_wr(3'h6, 8'h00);
            nvm_read(8'h00, {8'h00, a8}, d16);
            chk(d16[7:0], exp_byte(a8, seed[7:0]), "data byte");
            reg_rd(3'h6, rv); chk(rv[0], 0, "flag clear");
        end
        // Refused: no gate, then gate without unlock
        nvm_write(8'h00, 16'h0010, 16'h00a5);
        reg_wr(3'h4, 8'h04); reg_wr(3'h4, 8'h06);
        reg_rd(3'h6, rv); chk(rv[0], 0, "refused");
        // Program block: erase, four words, read back direct and wrapped
        nvm_write(8'h94, 16'h0020, 16'h0000);
        for (i = 0; i < 4; i = i + 1) begin
            seed = xs(seed);
            word[i] = seed[13:0];
            nvm_write(8'h84, 16'h0020 + i, {2'b00, seed[13:0]});
        end
        for (i = 0; i < 8; i = i + 1) begin
            nvm_read(8'h80, ((i < 4) ? 16'h0020 : 16'h1c20) + i[1:0], d16);
            chk(d16, {2'b00, word[i[1:0]]}, "prog word");
        end
        nvm_read(8'h80, 16'h0024, d16);
        chk(d16, 16'h3fff, "erased");
        // Protected: programmer locked out, data still works, program blocks held
        seed = xs(seed);
        code_protect <= 1'b1;
        // Slice 0 holds the words under test; the other slices are random
        write_protect <= {seed[3:1], 1'b1};
        @(posedge clock);
        #1 chk(ext_prog_grant, 0, "grant");
        nvm_write(8'h04, 16'h0005, {8'h00, seed[15:8]});
        nvm_read(8'h00, 16'h0005, d16); chk(d16[7:0], seed[15:8], "prot data");
        for (i = 0; i < 4; i = i + 1) nvm_write(8'h84, 16'h0020 + i, {2'b00, ~word[i]});
        for (i = 0; i < 4; i = i + 1) begin
            nvm_read(8'h80, 16'h0020 + i, d16);
            chk(d16, {2'b00, word[i]}, "prot word");
        end
        end_of_test;
    end
endmodule // tb_nva_access
bind nva_access nva_access_asserts #(.WRITE_CYC(WRITE_CYC)) u_nva_access_asserts (
    .CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .CODE_PROTECT(CODE_PROTECT), .EXT_PROG_REQ(EXT_PROG_REQ), .EXT_PROG_GRANT(EXT_PROG_GRANT),
    .PUMP_ON(PUMP_ON), .WRITE_DONE_FLAG(WRITE_DONE_FLAG), .BUSY(BUSY));
